// ==== pkg/psm_pkg.sv ====
// Package for the program sequencer and data memory map of a 4-bit core.
// Assumes one system clock and an active-low asynchronous reset.
package psm_pkg;

   // Program side
   localparam int PC_W = 9;
   localparam int INSTR_W = 16;
   localparam int ROM_WORDS = 512;
   localparam logic [8:0] PC_RESET = 9'h000;
   localparam logic [8:0] PC_LAST = 9'h1FF;
   localparam logic [8:0] PC_ONE = 9'h001;

   // Data side
   localparam int DADDR_W = 7;
   localparam int NIB_W = 4;
   localparam int ROW_W = 3;
   localparam int COL_W = 4;
   localparam int GEN_WORDS = 16;
   localparam logic [2:0] ROW_POINTER = 3'h0;
   localparam logic [2:0] GEN_ROW = 3'h0;
   localparam int N_PORTS = 3;
   localparam logic [6:0] ADDR_PORT0 = 7'h70;
   localparam logic [6:0] ADDR_ZERO_LO = 7'h74;
   localparam logic [6:0] ADDR_ZERO_HI = 7'h7D;
   localparam logic [6:0] ADDR_SW_LO = 7'h7E;
   localparam logic [6:0] ADDR_SW_HI = 7'h7F;
   localparam int SW_BCD_BIT = 0;
   localparam int SW_CMP_BIT = 3;
   localparam int SW_CY_BIT = 2;
   localparam int SW_Z_BIT = 1;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [3:0] PORT_RESET = 4'h0;
   localparam logic [3:0] PORT_OE_N_RESET = 4'hF;

   typedef enum logic [2:0] {next_op, jump_op, call_op, return_op, skip_op} psm_seq_op_t;

   typedef struct packed {
      psm_seq_op_t op;
      logic [8:0] target;
      logic skip_cond;
   } psm_seq_cmd_t;

   typedef struct packed {
      logic en;
      logic we;
      logic use_greg;
      logic [6:0] addr;
      logic [3:0] wdata;
   } psm_dmem_req_t;

   typedef struct packed {
      logic bcd;
      logic cmp;
      logic cy;
      logic z;
   } psm_status_t;

   function automatic logic [8:0] psm_pc_inc(input logic [8:0] pc);
      return 9'(pc + PC_ONE);
   endfunction

   function automatic logic [6:0] psm_greg_addr(input logic [3:0] col);
      return {ROW_POINTER, col};
   endfunction

endpackage

// ==== rtl/psm_dmem.sv ====
// Nibble-wide data memory: general row, port registers, status word.
// Assumes port pins are synchronous to clk_sys; one access per cycle.
`timescale 1ns/1ps
module psm_dmem import psm_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Access
   input wire psm_dmem_req_t req,
   output logic [3:0] rdata_q,
   // Port pins
   input wire logic [N_PORTS-1:0][3:0] port_pin_in,
   output logic [N_PORTS-1:0][3:0] port_out_q,
   output logic [N_PORTS-1:0][3:0] port_oe_n_q,
   // Status word
   output psm_status_t status_q
);

   logic [3:0] gen_mem [GEN_WORDS];
   logic [6:0] addr;
   logic [6:0] port_off;
   logic port_hit;
   logic [3:0] rd_val;

   assign addr = req.use_greg ? psm_greg_addr(req.addr[3:0]) : req.addr;
   assign port_off = 7'(addr - ADDR_PORT0);
   assign port_hit = (addr >= ADDR_PORT0) && (port_off < 7'(N_PORTS));

   always_comb begin
      rd_val = NIB_ZERO;
      if (addr[6:4] == GEN_ROW) begin
         rd_val = gen_mem[addr[3:0]];
      end else if (port_hit) begin
         rd_val = port_pin_in[port_off[1:0]];
      end else if (addr == ADDR_SW_LO) begin
         rd_val = {3'h0, status_q.bcd};
      end else if (addr == ADDR_SW_HI) begin
         rd_val = {status_q.cmp, status_q.cy, status_q.z, 1'b0};
      end
   end

   // Read old value and write new in one access
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= NIB_ZERO;
      end else if (req.en) begin
         rdata_q <= rd_val;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (req.en && req.we && addr[6:4] == GEN_ROW) begin
         gen_mem[addr[3:0]] <= req.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         port_out_q <= {N_PORTS{PORT_RESET}};
         port_oe_n_q <= {N_PORTS{PORT_OE_N_RESET}};
      end else if (req.en && req.we && port_hit) begin
         port_out_q[port_off[1:0]] <= req.wdata;
         port_oe_n_q[port_off[1:0]] <= NIB_ZERO;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         status_q <= '0;
      end else if (req.en && req.we) begin
         if (addr == ADDR_SW_LO) begin
            status_q.bcd <= req.wdata[SW_BCD_BIT];
         end else if (addr == ADDR_SW_HI) begin
            status_q.cmp <= req.wdata[SW_CMP_BIT];
            status_q.cy <= req.wdata[SW_CY_BIT];
            status_q.z <= req.wdata[SW_Z_BIT];
         end
      end
   end

   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
      req.en && !req.we && addr >= ADDR_ZERO_LO && addr <= ADDR_ZERO_HI |=> rdata_q == NIB_ZERO)
      else $error("reserved system location read nonzero");

   a_port_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
      req.en && req.we && port_hit |=> port_oe_n_q[$past(port_off[1:0])] == NIB_ZERO
      && port_out_q[$past(port_off[1:0])] == $past(req.wdata))
      else $error("port write did not enter output mode");

   a_port_pin_read: assert property (@(posedge clk_sys) disable iff (!nrst)
      req.en && port_hit |=> rdata_q == $past(port_pin_in[port_off[1:0]]))
      else $error("port read did not return pin level");

   a_greg_row: assert property (@(posedge clk_sys) disable iff (!nrst)
      req.en && req.use_greg |=> rdata_q == $past(gen_mem[req.addr[3:0]]))
      else $error("general register did not read row zero");

   c_port_write: cover property (@(posedge clk_sys) disable iff (!nrst) req.en && req.we && port_hit);

endmodule // psm_dmem

// ==== rtl/psm_sequencer.sv ====
// Program counter, one-level stack, program memory and data memory map.
// Assumes an outside decoder presents one command per executed instruction.
`timescale 1ns/1ps
module psm_sequencer import psm_pkg::*; #(
   parameter int ROM_DEPTH = ROM_WORDS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Program image load
   input wire logic rom_we,
   input wire logic [PC_W-1:0] rom_waddr,
   input wire logic [INSTR_W-1:0] rom_wdata,
   // Sequencing
   input wire logic step,
   input wire psm_seq_cmd_t cmd,
   output logic [PC_W-1:0] pc_q,
   output logic [PC_W-1:0] stack_q,
   output logic [INSTR_W-1:0] instr_q,
   output logic nop_q,
   // Data memory
   input wire psm_dmem_req_t dmem_req,
   output logic [NIB_W-1:0] dmem_rdata_q,
   input wire logic [N_PORTS-1:0][3:0] port_pin_in,
   output logic [N_PORTS-1:0][3:0] port_out_q,
   output logic [N_PORTS-1:0][3:0] port_oe_n_q,
   output psm_status_t status_word_q
);

   logic [INSTR_W-1:0] rom [ROM_DEPTH];
   logic [PC_W-1:0] pc_d;
   logic exec;

   // A skipped word consumes its step but does nothing
   assign exec = step && !nop_q;

   always_comb begin
      pc_d = pc_q;
      if (step) begin
         if (nop_q) begin
            pc_d = psm_pc_inc(pc_q);
         end else begin
            case (cmd.op)
               jump_op, call_op: begin
                  pc_d = cmd.target;
               end
               return_op: begin
                  pc_d = stack_q;
               end
               next_op, skip_op: begin
                  pc_d = psm_pc_inc(pc_q);
               end
               default: begin
                  pc_d = psm_pc_inc(pc_q);
               end
            endcase
         end
      end
   end

   // Program counter
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pc_q <= PC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end

   // One-level return stack
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stack_q <= PC_RESET;
      end else if (exec && cmd.op == call_op) begin
         stack_q <= psm_pc_inc(pc_q);
      end
   end

   // Skip shadow
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         nop_q <= 1'b0;
      end else if (step) begin
         nop_q <= exec && cmd.op == skip_op && cmd.skip_cond;
      end
   end

   // Program memory, one full word per address
   always_ff @(posedge clk_sys) begin
      if (rom_we) begin
         rom[rom_waddr] <= rom_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         instr_q <= '0;
      end else begin
         instr_q <= rom[pc_d];
      end
   end

   psm_dmem u_dmem (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .req(dmem_req),
      .rdata_q(dmem_rdata_q),
      .port_pin_in(port_pin_in),
      .port_out_q(port_out_q),
      .port_oe_n_q(port_oe_n_q),
      .status_q(status_word_q)
   );

   // Checks

   a_pc_reset: assert property (@(posedge clk_sys)
      !nrst |-> pc_q == PC_RESET && !nop_q)
      else $error("counter not cleared under reset");

   a_pc_next: assert property (@(posedge clk_sys) disable iff (!nrst)
      exec && cmd.op == next_op |=> pc_q == 9'($past(pc_q) + PC_ONE))
      else $error("ordinary step did not add one");

   a_pc_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
      exec && cmd.op == next_op && pc_q == PC_LAST |=> pc_q == PC_RESET)
      else $error("counter did not wrap as nine bits");

   a_jump_load: assert property (@(posedge clk_sys) disable iff (!nrst)
      exec && (cmd.op == jump_op || cmd.op == call_op) |=> pc_q == $past(cmd.target))
      else $error("jump or call target not loaded");

   a_call_save: assert property (@(posedge clk_sys) disable iff (!nrst)
      exec && cmd.op == call_op |=> stack_q == 9'($past(pc_q) + PC_ONE))
      else $error("call did not save next address");

   a_return_load: assert property (@(posedge clk_sys) disable iff (!nrst)
      exec && cmd.op == return_op |=> pc_q == $past(stack_q))
      else $error("return did not restore saved address");

   a_skip_taken: assert property (@(posedge clk_sys) disable iff (!nrst)
      exec && cmd.op == skip_op && cmd.skip_cond |=> nop_q && pc_q == 9'($past(pc_q) + PC_ONE))
      else $error("taken skip did not mark next word");

   a_nop_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
      step && nop_q |=> !nop_q && pc_q == 9'($past(pc_q) + PC_ONE) && $stable(stack_q))
      else $error("skipped word was not a no-operation");

   a_pc_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      !step |=> $stable(pc_q) && $stable(nop_q))
      else $error("counter moved without a step");

   c_call_return: cover property (@(posedge clk_sys) disable iff (!nrst)
      exec && cmd.op == call_op ##[1:20] exec && cmd.op == return_op);

   c_skip_taken: cover property (@(posedge clk_sys) disable iff (!nrst)
      exec && cmd.op == skip_op && cmd.skip_cond ##[1:10] step && nop_q);

   c_pc_wrap: cover property (@(posedge clk_sys) disable iff (!nrst)
      pc_q == PC_LAST ##1 pc_q == PC_RESET);

endmodule // psm_sequencer

// ==== tb/psm_sequencer_test.sv ====
// Self-checking bench for the program sequencer and data memory map.
// Assumes psm_pkg is compiled first; inputs change on the falling edge.
`timescale 1ns/1ps
module psm_sequencer_test import psm_pkg::*; ;
   logic clk_sys, nrst, rom_we, step;
   logic [8:0] rom_waddr;
   logic [15:0] rom_wdata;
   psm_seq_cmd_t cmd;
   psm_dmem_req_t dmem_req;
   logic [2:0][3:0] port_pin_in, port_out_q, port_oe_n_q, pout_m, poe_m;
   logic [8:0] pc_q, stack_q, pc_m, stk_m;
   logic [15:0] instr_q, rnd;
   logic nop_q, nop_m;
   logic [3:0] dmem_rdata_q, rd_m;
   psm_status_t status_word_q, st_m;
   logic [15:0] rom_m [512];
   logic [3:0] ram_m [16];
   int num_errors, check_count;

   psm_sequencer dut_u (.clk_sys(clk_sys), .nrst(nrst), .rom_we(rom_we), .rom_waddr(rom_waddr),
      .rom_wdata(rom_wdata), .step(step), .cmd(cmd), .pc_q(pc_q), .stack_q(stack_q), .instr_q(instr_q),
      .nop_q(nop_q), .dmem_req(dmem_req), .dmem_rdata_q(dmem_rdata_q), .port_pin_in(port_pin_in),
      .port_out_q(port_out_q), .port_oe_n_q(port_oe_n_q), .status_word_q(status_word_q));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic do_reset();
      nrst = 1'b0;
      pc_m = 9'h000;
      stk_m = 9'h000;
      nop_m = 1'b0;
      rd_m = 4'h0;
      pout_m = 12'h000;
      poe_m = 12'hFFF;
      st_m = 4'h0;
      repeat (16) @(negedge clk_sys);
      chk("pc reset", 16'(pc_m), 16'(pc_q));
      chk("stack reset", 16'(stk_m), 16'(stack_q));
      chk("port oe reset", 16'(poe_m), 16'(port_oe_n_q));
      chk("port out reset", 16'(pout_m), 16'(port_out_q));
      chk("status reset", 16'(st_m), 16'(status_word_q));
      chk("instr reset", 16'h0000, instr_q);
      chk("rdata reset", 16'(rd_m), 16'(dmem_rdata_q));
      nrst = 1'b1;
   endtask

   // One stepped instruction; step stays high for back-to-back use
   task automatic seq(input psm_seq_op_t op, input logic [8:0] t, input logic c);
      cmd = '{op, t, c};
      step = 1'b1;
      if (nop_m) begin
         pc_m = pc_m + 9'h001;
         nop_m = 1'b0;
      end else begin
         case (op)
            jump_op: pc_m = t;
            call_op: begin
               stk_m = pc_m + 9'h001;
               pc_m = t;
            end
            return_op: pc_m = stk_m;
            skip_op: begin
               nop_m = c;
               pc_m = pc_m + 9'h001;
            end
            default: pc_m = pc_m + 9'h001;
         endcase
      end
      @(negedge clk_sys);
      chk("pc", 16'(pc_m), 16'(pc_q));
      chk("stack", 16'(stk_m), 16'(stack_q));
      chk("nop", 16'(nop_m), 16'(nop_q));
      chk("instr", rom_m[pc_m], instr_q);
   endtask

   // One data memory access; en stays high for back-to-back use
   task automatic mem(input logic we, input logic g, input logic [6:0] a, input logic [3:0] w);
      logic [6:0] ea;
      rnd = lfsr(rnd);
      port_pin_in = rnd[11:0];
      dmem_req = '{1'b1, we, g, a, w};
      ea = g ? {ROW_POINTER, a[3:0]} : a;
      if (ea[6:4] == 3'h0) rd_m = ram_m[ea[3:0]];
      else if (ea >= 7'h70 && ea <= 7'h72) rd_m = rnd[4*ea[1:0] +: 4];
      else if (ea == 7'h7E) rd_m = {3'h0, st_m.bcd};
      else if (ea == 7'h7F) rd_m = {st_m.cmp, st_m.cy, st_m.z, 1'b0};
      else rd_m = 4'h0;
      if (we) begin
         if (ea[6:4] == 3'h0) ram_m[ea[3:0]] = w;
         else if (ea >= 7'h70 && ea <= 7'h72) begin
            pout_m[ea[1:0]] = w;
            poe_m[ea[1:0]] = 4'h0;
         end else if (ea == 7'h7E) st_m.bcd = w[0];
         else if (ea == 7'h7F) begin
            st_m.cmp = w[3];
            st_m.cy = w[2];
            st_m.z = w[1];
         end
      end
      @(negedge clk_sys);
      chk("rdata", 16'(rd_m), 16'(dmem_rdata_q));
      chk("port out", 16'(pout_m), 16'(port_out_q));
      chk("port oe", 16'(poe_m), 16'(port_oe_n_q));
      chk("status", 16'(st_m), 16'(status_word_q));
   endtask

   initial begin
      #100000;
      num_errors++;
      summarize();
   end

   initial begin
      rom_we = 1'b0;
      rom_waddr = 9'h000;
      rom_wdata = 16'h0000;
      step = 1'b0;
      cmd = '0;
      dmem_req = '0;
      port_pin_in = 12'h000;
      rnd = 16'hAA33;
      num_errors = 0;
      check_count = 0;
      // Start released so the reset edge reaches every asynchronously reset flop
      nrst = 1'b1;
      #1;
      do_reset();
      @(negedge clk_sys);
      // Load the whole program image with random words
      for (int a = 0; a < 512; a++) begin
         rnd = lfsr(rnd);
         rom_we = 1'b1;
         rom_waddr = 9'(a);
         rom_wdata = rnd;
         rom_m[a] = rnd;
         @(negedge clk_sys);
      end
      rom_we = 1'b0;
      @(negedge clk_sys);
      chk("instr at start", rom_m[0], instr_q);
      // Wrap at the top, then call, skipped call and return
      seq(jump_op, 9'h1FF, 1'b0);
      seq(next_op, 9'h0F0, 1'b1);
      seq(call_op, 9'h0A5, 1'b0);
      seq(skip_op, 9'h000, 1'b1);
      seq(call_op, 9'h133, 1'b0);
      seq(return_op, 9'h077, 1'b0);
      seq(skip_op, 9'h000, 1'b0);
      seq(call_op, 9'h1FF, 1'b0);
      seq(return_op, 9'h000, 1'b0);
      for (int i = 0; i < 400; i++) begin
         rnd = lfsr(rnd);
         seq(psm_seq_op_t'(rnd[2:0] % 3'h5), rnd[15:7], rnd[3]);
      end
      step = 1'b0;
      @(negedge clk_sys);
      // Every address: read, write, read again, then random mix
      for (int p = 0; p < 3; p++) begin
         for (int a = 0; a < 128; a++) begin
            mem(p == 1, 1'b0, 7'(a), rnd[15:12]);
         end
      end
      for (int i = 0; i < 300; i++) begin
         mem(rnd[13], rnd[14], rnd[10:4], rnd[3:0]);
      end
      dmem_req = '0;
      do_reset();
      @(negedge clk_sys);
      seq(call_op, 9'h0C3, 1'b0);
      seq(return_op, 9'h000, 1'b0);
      step = 1'b0;
      mem(1'b0, 1'b1, 7'h75, 4'hA);
      summarize();
   end
endmodule // psm_sequencer_test
